// ### core/adc_seq_pkg.sv
// shared constants and types for the converter sequencer
package adc_seq_pkg;

   // ----------------------------------------------------------------
   // conversion geometry
   // ----------------------------------------------------------------
   localparam int RESULT_BITS      = 10;
   localparam int TAD_PER_CONV     = 12;
   localparam int TRIGGER_SOURCES  = 17;
   localparam int CLK_PERIOD_NS    = 4;

   localparam logic [3:0] TAD_LAST      = 4'hb;
   localparam logic [3:0] TAD_FIRST_BIT = 4'h1;
   localparam logic [3:0] TAD_LAST_BIT  = 4'ha;

   // ----------------------------------------------------------------
   // clock select encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] CLKSEL_DIV2  = 3'h0;
   localparam logic [2:0] CLKSEL_DIV4  = 3'h4;
   localparam logic [2:0] CLKSEL_DIV8  = 3'h1;
   localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
   localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
   localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
   localparam logic [1:0] CLKSEL_RC_LOW = 2'h3;

   // prescaler terminal counts (divisor minus one)
   localparam logic [5:0] PRESC_DIV2  = 6'h01;
   localparam logic [5:0] PRESC_DIV4  = 6'h03;
   localparam logic [5:0] PRESC_DIV8  = 6'h07;
   localparam logic [5:0] PRESC_DIV16 = 6'h0f;
   localparam logic [5:0] PRESC_DIV32 = 6'h1f;
   localparam logic [5:0] PRESC_DIV64 = 6'h3f;

   // ----------------------------------------------------------------
   // field layout of the first control register readback
   // ----------------------------------------------------------------
   localparam int CTRL_ON_POS   = 0;
   localparam int CTRL_GO_POS   = 1;
   localparam int CTRL_CHS_LSB  = 2;
   localparam int CTRL_CHS_MSB  = 7;

   // ----------------------------------------------------------------
   // reset values and trigger codes
   // ----------------------------------------------------------------
   localparam logic [9:0] SAR_START   = 10'h200;
   localparam logic [7:0] RESULT_RST  = 8'h00;
   localparam logic [4:0] TRIG_NONE   = 5'h00;
   localparam logic [4:0] TRIG_LAST   = 5'h11;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_DELAY   = 3'b010,
      ST_CONVERT = 3'b100
   } seq_state_type;

endpackage : adc_seq_pkg

// ### core/adc_sequencer_control.sv
// successive-approximation converter sequencer: clocking, start/abort, sleep, trigger, result
`timescale 1ns/100ps

module adc_sequencer_control
   import adc_seq_pkg::*;
#(
   parameter int NUM_SOURCES = TRIGGER_SOURCES
) (
   input  wire logic                   SYS_CLK_I,
   input  wire logic                   NRST_I,
   input  wire logic                   ADC_ON_I,
   input  wire logic [5:0]             CHANNEL_SELECT_I,
   input  wire logic                   GO_SET_I,
   input  wire logic                   GO_CLEAR_I,
   input  wire logic [2:0]             CONV_CLOCK_SELECT_I,
   input  wire logic                   RESULT_FORMAT_SELECT_I,
   input  wire logic [4:0]             AUTO_TRIGGER_SELECT_I,
   input  wire logic [NUM_SOURCES-1:0] TRIGGER_SOURCES_I,
   input  wire logic                   SLEEP_I,
   input  wire logic                   RC_TICK_I,
   input  wire logic                   INSTR_TICK_I,
   input  wire logic                   COMPARE_I,
   input  wire logic                   FLAG_CLEAR_I,
   input  wire logic                   CONV_DONE_IRQ_ENABLE_I,
   input  wire logic                   PERIPH_IRQ_ENABLE_I,
   input  wire logic                   GLOBAL_IRQ_ENABLE_I,
   output logic                        CONV_GO_O,
   output logic                        CONV_DONE_FLAG_O,
   output logic [7:0]                  RESULT_HIGH_O,
   output logic [7:0]                  RESULT_LOW_O,
   output logic [7:0]                  CONTROL_FIRST_O,
   output logic [9:0]                  TRIAL_CODE_O,
   output logic                        HOLD_O,
   output logic                        CONVERTER_ACTIVE_O,
   output logic                        WAKE_REQUEST_O,
   output logic                        WAKE_VECTOR_O,
   output logic                        IRQ_O
);

   // ----------------------------------------------------------------
   // state record
   // ----------------------------------------------------------------
   typedef struct packed {
      seq_state_type state;
      logic          go;
      logic          flag;
      logic [9:0]    code;
      logic [3:0]    resolved;
      logic [3:0]    tad_count;
      logic [5:0]    presc;
      logic [2:0]    prev_sel;
      logic          trig_prev;
      logic [7:0]    res_high;
      logic [7:0]    res_low;
      logic          sleep_off;
      logic          wake;
      logic          wake_vector;
   } regs_type;

   localparam regs_type REGS_RST = '{
      state:       ST_IDLE,
      go:          1'b0,
      flag:        1'b0,
      code:        SAR_START,
      resolved:    4'h0,
      tad_count:   4'h0,
      presc:       6'h00,
      prev_sel:    CLKSEL_DIV2,
      trig_prev:   1'b0,
      res_high:    RESULT_RST,
      res_low:     RESULT_RST,
      sleep_off:   1'b0,
      wake:        1'b0,
      wake_vector: 1'b0
   };

   regs_type r;
   regs_type next_r;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic is_rc(input logic [2:0] sel);
      return sel[1:0] == CLKSEL_RC_LOW;
   endfunction : is_rc

   // rc codes never use this limit; the rc path bypasses the prescaler
   function automatic logic [5:0] presc_limit(input logic [2:0] sel);
      logic [5:0] lim;
      lim = PRESC_DIV2;
      unique case (sel)
         CLKSEL_DIV2:  lim = PRESC_DIV2;
         CLKSEL_DIV4:  lim = PRESC_DIV4;
         CLKSEL_DIV8:  lim = PRESC_DIV8;
         CLKSEL_DIV16: lim = PRESC_DIV16;
         CLKSEL_DIV32: lim = PRESC_DIV32;
         CLKSEL_DIV64: lim = PRESC_DIV64;
         default:      lim = PRESC_DIV2;
      endcase
      return lim;
   endfunction : presc_limit

   // bits not yet resolved copy the last resolved bit
   function automatic logic [9:0] fill_partial(input logic [9:0] code, input logic [3:0] nres);
      logic [9:0] res;
      logic       last;
      res  = 10'h000;
      last = 1'b0;
      for (int i = 0; i < RESULT_BITS; i++) begin
         if (4'(i) < nres) begin
            res[9-i] = code[9-i];
            last     = code[9-i];
         end else begin
            res[9-i] = (nres == 4'h0) ? 1'b0 : last;
         end
      end
      return res;
   endfunction : fill_partial

   function automatic logic [15:0] justify(input logic [9:0] value, input logic right);
      if (right) begin
         return {6'h00, value};
      end
      return {value, 6'h00};
   endfunction : justify

   // ----------------------------------------------------------------
   // combinational decode
   // ----------------------------------------------------------------
   logic       rc_sel;
   logic       tad_tick;
   logic       trig_level;
   logic       trig_edge;
   logic       sel_changed;
   logic [4:0] trig_index;

   assign rc_sel      = is_rc(CONV_CLOCK_SELECT_I);
   assign sel_changed = CONV_CLOCK_SELECT_I != r.prev_sel;
   assign trig_index  = AUTO_TRIGGER_SELECT_I - 5'h01;
   // codes past the last source decode as no trigger, like code zero

   always_comb begin
      trig_level = 1'b0;
      if (AUTO_TRIGGER_SELECT_I != TRIG_NONE && AUTO_TRIGGER_SELECT_I <= TRIG_LAST) begin
         trig_level = TRIGGER_SOURCES_I[trig_index];
      end
   end

   assign trig_edge = trig_level && !r.trig_prev && !SLEEP_I;

   // rc periods arrive as ticks; sysclk periods come from the prescaler
   assign tad_tick = rc_sel ? RC_TICK_I : (r.presc == presc_limit(CONV_CLOCK_SELECT_I));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        powered;
      logic        start_req;
      logic        complete;
      logic [9:0]  final_code;
      logic [15:0] packed_res;
      logic [3:0]  bit_index;

      next_r     = r;
      powered    = 1'b0;
      start_req  = 1'b0;
      complete   = 1'b0;
      final_code = 10'h000;
      packed_res = 16'h0000;
      bit_index  = 4'h0;

      next_r.prev_sel  = CONV_CLOCK_SELECT_I;
      next_r.trig_prev = trig_level;
      next_r.wake      = 1'b0;

      // prescaler free-runs between restarts
      if (sel_changed || tad_tick) begin
         next_r.presc = 6'h00;
      end else begin
         next_r.presc = r.presc + 6'h01;
      end

      if (!SLEEP_I) begin
         next_r.sleep_off = 1'b0;
      end
      powered = ADC_ON_I && !next_r.sleep_off;

      if (GO_SET_I || trig_edge) begin
         start_req = 1'b1;
      end

      unique case (r.state)
         ST_IDLE: begin
            // a start while busy is ignored; go already reads one then
            if (start_req && ADC_ON_I && !r.sleep_off) begin
               next_r.go        = 1'b1;
               next_r.code      = SAR_START;
               next_r.resolved  = 4'h0;
               next_r.tad_count = 4'h0;
               next_r.presc     = 6'h00;
               next_r.state     = rc_sel ? ST_DELAY : ST_CONVERT;
            end
         end
         ST_DELAY: begin
            // one instruction of slack so the sleep instruction can run
            if (INSTR_TICK_I) begin
               next_r.presc = 6'h00;
               next_r.state = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            // period 0 samples, periods 1..10 resolve msb first, period 11 closes
            if (tad_tick) begin
               next_r.tad_count = r.tad_count + 4'h1;
               if (r.tad_count >= TAD_FIRST_BIT && r.tad_count <= TAD_LAST_BIT) begin
                  bit_index = TAD_LAST_BIT - r.tad_count;
                  next_r.code[bit_index] = COMPARE_I;
                  if (bit_index != 4'h0) begin
                     next_r.code[bit_index - 4'h1] = 1'b1;
                  end
                  next_r.resolved = r.resolved + 4'h1;
               end
               if (r.tad_count == TAD_LAST) begin
                  complete = 1'b1;
               end
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase

      if (r.state != ST_IDLE) begin
         if (complete) begin
            // format is taken at load time, not at start
            final_code       = r.code;
            packed_res       = justify(final_code, RESULT_FORMAT_SELECT_I);
            next_r.res_high  = packed_res[15:8];
            next_r.res_low   = packed_res[7:0];
            next_r.go        = 1'b0;
            next_r.flag      = 1'b1;
            next_r.state     = ST_IDLE;
            if (SLEEP_I) begin
               if (CONV_DONE_IRQ_ENABLE_I) begin
                  next_r.wake        = 1'b1;
                  next_r.wake_vector = GLOBAL_IRQ_ENABLE_I && PERIPH_IRQ_ENABLE_I;
               end else begin
                  next_r.sleep_off = 1'b1;
               end
            end
         end else if (GO_CLEAR_I) begin
            // an abort never sets the flag; only a finished conversion does
            final_code      = fill_partial(r.code, r.resolved);
            packed_res      = justify(final_code, RESULT_FORMAT_SELECT_I);
            next_r.res_high = packed_res[15:8];
            next_r.res_low  = packed_res[7:0];
            next_r.go       = 1'b0;
            next_r.state    = ST_IDLE;
         end else if (SLEEP_I && !rc_sel) begin
            // sysclk stops in sleep, so the conversion cannot finish
            next_r.go        = 1'b0;
            next_r.sleep_off = 1'b1;
            next_r.state     = ST_IDLE;
         end else if (!powered) begin
            // switching off drops the conversion without touching the results
            next_r.go    = 1'b0;
            next_r.state = ST_IDLE;
         end
      end else if (SLEEP_I && !rc_sel && ADC_ON_I) begin
         // an idle converter on a sysclk select is also held off in sleep
         next_r.sleep_off = 1'b1;
      end

      // set beats clear when both land together
      if (FLAG_CLEAR_I && !complete) begin
         next_r.flag = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // reset also ends a conversion in flight and any sleep power-off
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         r <= REGS_RST;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign CONV_GO_O          = r.go;
   assign CONV_DONE_FLAG_O   = r.flag;
   assign RESULT_HIGH_O      = r.res_high;
   assign RESULT_LOW_O       = r.res_low;
   assign TRIAL_CODE_O       = r.code;
   assign HOLD_O             = r.state == ST_CONVERT;
   // on readback follows software even while sleep holds the converter off
   assign CONVERTER_ACTIVE_O = ADC_ON_I && !r.sleep_off;
   // vector choice latches with each wake and holds until the next one
   assign WAKE_REQUEST_O     = r.wake;
   assign WAKE_VECTOR_O      = r.wake_vector;
   assign IRQ_O              = r.flag && CONV_DONE_IRQ_ENABLE_I && PERIPH_IRQ_ENABLE_I
                               && GLOBAL_IRQ_ENABLE_I;

   always_comb begin
      CONTROL_FIRST_O                            = 8'h00;
      CONTROL_FIRST_O[CTRL_CHS_MSB:CTRL_CHS_LSB] = CHANNEL_SELECT_I;
      CONTROL_FIRST_O[CTRL_GO_POS]               = r.go;
      CONTROL_FIRST_O[CTRL_ON_POS]               = ADC_ON_I;
   end

endmodule : adc_sequencer_control

// ### sim/adc_core_model.sv
// comparator side of the sample-and-hold core facing the sequencer
`timescale 1ns/100ps
module adc_core_model (
   input  wire logic       clk_i,
   input  wire logic [9:0] trial_code_i,
   input  wire logic       hold_i,
   input  wire logic [9:0] vin_i,
   output logic            compare_o
);
   logic toggle = 1'b0;
   always @(posedge clk_i) toggle <= !toggle;
   // outside a hold the decision means nothing, so it wanders every cycle
   assign compare_o = hold_i ? (trial_code_i <= vin_i) : toggle;
endmodule : adc_core_model

// ### sim/adc_sequencer_control_sva.sv
// port-level assertions for the converter sequencer
`timescale 1ns/100ps
module adc_seq_checker
   import adc_seq_pkg::*;
(
   input wire logic       SYS_CLK_I,
   input wire logic       NRST_I,
   input wire logic       ADC_ON_I,
   input wire logic [5:0] CHANNEL_SELECT_I,
   input wire logic       GO_SET_I,
   input wire logic       GO_CLEAR_I,
   input wire logic [2:0] CONV_CLOCK_SELECT_I,
   input wire logic       RESULT_FORMAT_SELECT_I,
   input wire logic       SLEEP_I,
   input wire logic       FLAG_CLEAR_I,
   input wire logic       CONV_DONE_IRQ_ENABLE_I,
   input wire logic       PERIPH_IRQ_ENABLE_I,
   input wire logic       GLOBAL_IRQ_ENABLE_I,
   input wire logic       CONV_GO_O,
   input wire logic       CONV_DONE_FLAG_O,
   input wire logic [7:0] RESULT_HIGH_O,
   input wire logic [7:0] RESULT_LOW_O,
   input wire logic [7:0] CONTROL_FIRST_O,
   input wire logic       HOLD_O,
   input wire logic       CONVERTER_ACTIVE_O,
   input wire logic       WAKE_REQUEST_O,
   input wire logic       WAKE_VECTOR_O,
   input wire logic       IRQ_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!NRST_I);
   localparam int DIV2_RUN = 24;
   // ----------------------------------------------------------------
   // go-high run length, poisoned once the select leaves divide-by-two
   // ----------------------------------------------------------------
   logic [7:0] run_len;
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I || !CONV_GO_O) run_len <= 8'h00;
      else if (CONV_CLOCK_SELECT_I != CLKSEL_DIV2 || run_len == 8'hff) run_len <= 8'hff;
      else run_len <= run_len + 8'h01;
   end
   start_take_a: assert property (GO_SET_I && !GO_CLEAR_I && !CONV_GO_O && ADC_ON_I && !SLEEP_I
      && CONVERTER_ACTIVE_O |=> CONV_GO_O) else $error("go not taken");
   off_refuse_a: assert property (!ADC_ON_I && !CONV_GO_O |=> !CONV_GO_O) else $error("start while off");
   div2_length_a: assert property ($fell(CONV_GO_O) && run_len != 8'hff && !$past(GO_CLEAR_I) && $past(ADC_ON_I)
      && $past(NRST_I) && !$past(SLEEP_I) |-> run_len == DIV2_RUN) else $error("wrong conversion length");
   flag_hold_a: assert property (CONV_DONE_FLAG_O && !FLAG_CLEAR_I |=> CONV_DONE_FLAG_O) else $error("flag lost");
   flag_cause_a: assert property ($rose(CONV_DONE_FLAG_O) |-> $fell(CONV_GO_O)) else $error("flag without end");
   abort_stop_a: assert property (GO_CLEAR_I && CONV_GO_O |=> !CONV_GO_O && !HOLD_O && !$rose(CONV_DONE_FLAG_O))
      else $error("abort not honoured");
   sleep_ignore_a: assert property (SLEEP_I && !GO_SET_I && !CONV_GO_O |=> !CONV_GO_O) else $error("start in sleep");
   right_zero_a: assert property ($rose(CONV_DONE_FLAG_O) && $past(RESULT_FORMAT_SELECT_I)
      |-> RESULT_HIGH_O[7:2] == 6'h00) else $error("high not zero filled");
   left_zero_a: assert property ($rose(CONV_DONE_FLAG_O) && !$past(RESULT_FORMAT_SELECT_I)
      |-> RESULT_LOW_O[5:0] == 6'h00) else $error("low not zero filled");
   wake_vector_a: assert property (WAKE_REQUEST_O |-> $fell(CONV_GO_O) && CONV_DONE_FLAG_O && $past(SLEEP_I)
      && WAKE_VECTOR_O == ($past(GLOBAL_IRQ_ENABLE_I) && $past(PERIPH_IRQ_ENABLE_I))) else $error("bad wake");
   irq_level_a: assert property (IRQ_O == (CONV_DONE_FLAG_O && CONV_DONE_IRQ_ENABLE_I && PERIPH_IRQ_ENABLE_I
      && GLOBAL_IRQ_ENABLE_I)) else $error("irq level wrong");
   ctrl_readback_a: assert property (CONTROL_FIRST_O == {CHANNEL_SELECT_I, CONV_GO_O, ADC_ON_I})
      else $error("control readback wrong");
   cover property ($fell(CONV_GO_O) && run_len == DIV2_RUN);
   cover property (GO_CLEAR_I && HOLD_O);
   cover property ($rose(WAKE_REQUEST_O));
endmodule : adc_seq_checker

// ### sim/test_adc_sequencer_control.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module test_adc_sequencer_control;
   import adc_seq_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, on = 1'b0, go_set = 1'b0, go_clr = 1'b0, fmt = 1'b0, slp = 1'b0;
   logic        rc_tick = 1'b0, instr_tick = 1'b0, fclr = 1'b0, ie = 1'b0, pe = 1'b0, ge = 1'b0, cmp;
   logic [5:0]  chan = 6'h00;
   logic [2:0]  csel = 3'h0;
   logic [4:0]  tsel = 5'h00;
   logic [16:0] tsrc = 17'h00000;
   logic [9:0]  vin = 10'h000, trial;
   logic        go, flag, hold, act, wake, vec, irq;
   logic [7:0]  rhi, rlo, ctl;
   int          fails = 0, cmp_count = 0, n;
   always #2 clk = !clk;
   adc_sequencer_control #(.NUM_SOURCES(17)) dut_u (.SYS_CLK_I(clk), .NRST_I(nrst), .ADC_ON_I(on),
      .CHANNEL_SELECT_I(chan), .GO_SET_I(go_set), .GO_CLEAR_I(go_clr), .CONV_CLOCK_SELECT_I(csel),
      .RESULT_FORMAT_SELECT_I(fmt), .AUTO_TRIGGER_SELECT_I(tsel), .TRIGGER_SOURCES_I(tsrc), .SLEEP_I(slp),
      .RC_TICK_I(rc_tick), .INSTR_TICK_I(instr_tick), .COMPARE_I(cmp), .FLAG_CLEAR_I(fclr),
      .CONV_DONE_IRQ_ENABLE_I(ie), .PERIPH_IRQ_ENABLE_I(pe), .GLOBAL_IRQ_ENABLE_I(ge), .CONV_GO_O(go),
      .CONV_DONE_FLAG_O(flag), .RESULT_HIGH_O(rhi), .RESULT_LOW_O(rlo), .CONTROL_FIRST_O(ctl),
      .TRIAL_CODE_O(trial), .HOLD_O(hold), .CONVERTER_ACTIVE_O(act), .WAKE_REQUEST_O(wake),
      .WAKE_VECTOR_O(vec), .IRQ_O(irq));
   adc_core_model core_u (.clk_i(clk), .trial_code_i(trial), .hold_i(hold), .vin_i(vin), .compare_o(cmp));
   // ----------------------------------------------------------------
   // reference model and shared tasks
   // ----------------------------------------------------------------
   function automatic logic [15:0] pair(input logic [9:0] r, input logic f);
      return f ? {6'h00, r} : {r, 6'h00};
   endfunction : pair
   function automatic logic [9:0] partial(input logic [9:0] r, input int m);
      logic [9:0] p;
      p = r;
      for (int b = 9 - m; b >= 0; b--) p[b] = (m == 0) ? 1'b0 : r[10 - m];
      return p;
   endfunction : partial
   task automatic cyc(input int k = 1);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wait_idle();
      while (go === 1'b1 && n < 2000) begin
         cyc();
         n++;
      end
   endtask : wait_idle
   task automatic clear_flag();
      fclr = 1'b1;
      cyc();
      fclr = 1'b0;
      chk("flag clear", 16'h0000, 16'(flag));
      vin = 10'($urandom);
      fmt = 1'($urandom);
      chan = 6'($urandom);
   endtask : clear_flag
   task automatic start_go();
      go_set = 1'b1;
      cyc();
      go_set = 1'b0;
      n = 0;
   endtask : start_go
   task automatic rc_ticks(input int k);
      repeat (k) begin
         rc_tick = 1'b1;
         cyc();
         rc_tick = 1'b0;
         cyc(2);
      end
   endtask : rc_ticks
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      fails++;
      end_sim();
   end
   initial begin
      logic [2:0] sels [6];
      sels = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
      n = $urandom(80);
      cyc(4);
      chk("reset state", 16'h0000, 16'({go, flag, hold}));
      chk("reset result", 16'h0000, {rhi, rlo});
      chk("reset code", 16'h0200, 16'(trial));
      nrst = 1'b1;
      cyc();
      // enable first, start later, so acquisition precedes the go write
      on = 1'b1;
      cyc(4);
      for (int i = 0; i < 6; i++) begin
         csel = sels[i];
         {ie, pe, ge} = 3'($urandom);
         clear_flag();
         start_go();
         wait_idle();
         chk("length", 16'(12 * (2 << i)), 16'(n));
         chk("done flag", 16'h0001, 16'(flag));
         chk("result", pair(vin, fmt), {rhi, rlo});
         cyc(10);
         chk("flag sticky", 16'h0001, 16'(flag));
      end
      $display("test dividers done");
      csel = 3'h6;
      start_go();
      cyc(30);
      nrst = 1'b0;
      cyc();
      chk("reset mid", 16'h0000, 16'({go, hold, flag}));
      chk("reset mid result", 16'h0000, {rhi, rlo});
      nrst = 1'b1;
      csel = 3'h1;
      cyc(4);
      foreach (sels[m]) begin
         clear_flag();
         start_go();
         cyc(8 * (2 * m + 1) + 3);
         go_clr = 1'b1;
         cyc();
         go_clr = 1'b0;
         chk("abort go", 16'h0000, 16'({go, flag}));
         chk("abort result", pair(partial(vin, 2 * m), fmt), {rhi, rlo});
      end
      on = 1'b0;
      start_go();
      chk("go while off", 16'h0000, 16'(go));
      on = 1'b1;
      csel = 3'h0;
      cyc(2);
      $display("test abort done");
      for (int t = 0; t <= 18; t++) begin
         tsel = 5'(t);
         tsrc = (t >= 1 && t <= 17) ? ~(17'h00001 << (t - 1)) : 17'h1ffff;
         cyc();
         chk("other source", 16'h0000, 16'(go));
         tsrc = 17'h1ffff;
         cyc();
         chk("own source", 16'(t >= 1 && t <= 17), 16'(go));
         n = 0;
         wait_idle();
         tsrc = 17'h00000;
         cyc();
      end
      $display("test trigger done");
      csel = 3'h2;
      start_go();
      cyc(40);
      slp = 1'b1;
      cyc(2);
      chk("sleep abort", 16'h0001, 16'({go, act, ctl[0]}));
      chk("sleep keeps result", pair(vin, fmt), {rhi, rlo});
      slp = 1'b0;
      cyc();
      chk("awake active", 16'h0001, 16'(act));
      for (int g = 0; g < 3; g++) begin
         csel = (g == 1) ? 3'h7 : 3'h3;
         ie = (g < 2);
         pe = 1'b1;
         ge = (g == 1);
         clear_flag();
         start_go();
         rc_ticks(14);
         chk("rc start delay", 16'h0001, 16'(go));
         instr_tick = 1'b1;
         cyc();
         instr_tick = 1'b0;
         slp = 1'b1;
         rc_ticks(11);
         chk("rc running", 16'h0001, 16'(go));
         rc_tick = 1'b1;
         cyc();
         rc_tick = 1'b0;
         chk("rc done", 16'h0001, 16'({go, flag}));
         // with no wake the vector keeps the choice of the last one
         chk("wake", 16'({ie, ie ? ge : 1'b1}), 16'({wake, vec}));
         chk("rc result", pair(vin, fmt), {rhi, rlo});
         chk("sleep power", 16'({g < 2, 1'b1}), 16'({act, ctl[0]}));
         tsel = 5'h01;
         tsrc = 17'h00001;
         cyc();
         chk("trigger asleep", 16'h0000, 16'(go));
         tsrc = 17'h00000;
         slp = 1'b0;
         cyc();
      end
      $display("test sleep done");
      end_sim();
   end
endmodule : test_adc_sequencer_control
bind adc_sequencer_control adc_seq_checker chk_u (.*);
